// file: src/eppio_pkg.sv
// Purpose: constants for the eight pin io port
// Assumes: byte wide io space, offsets relative to the port block base
// Notes: one bit position table shared by select, direction and level registers
package eppio_pkg;
	localparam logic [15:0] PORT_BLOCK_BASE = 16'h1C00;
	localparam logic [7:0] OFF_FUNC_A = 8'h00;
	localparam logic [7:0] OFF_FUNC_B = 8'h02;
	localparam logic [7:0] OFF_DIR_A = 8'h04;
	localparam logic [7:0] OFF_DIR_B = 8'h06;
	localparam logic [7:0] OFF_LVL_A = 8'h0C;
	localparam logic [7:0] OFF_LVL_B = 8'h0E;
	localparam logic [7:0] OFF_INV_A = 8'h2C;
	localparam logic [7:0] OFF_INV_B = 8'h2E;
	localparam logic [7:0] OFF_FUNC_C = 8'h30;
	localparam logic [7:0] OFF_DIR_C = 8'h34;
	localparam logic [7:0] OFF_LVL_C = 8'h38;
	// register group per pin: 0 = a, 1 = b, 2 = c
	localparam logic [1:0] PIN_GRP [8] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2};
	localparam logic [2:0] PIN_BIT [8] = '{3'h1, 3'h0, 3'h1, 3'h5, 3'h6, 3'h2, 3'h3, 3'h4};
	// reset: pins 0..3 gpio inputs, pins 4..7 gpio outputs driven low
	localparam logic [7:0] RST_FUNC = 8'hFF;
	localparam logic [7:0] RST_DIR = 8'h0F;
	localparam logic [7:0] RST_LVL = 8'h00;
	localparam logic [7:0] RST_INV = 8'h00;
	localparam logic [7:0] INV_CAPABLE = 8'h0F;
	localparam int SYNC_STAGES = 3;
endpackage : eppio_pkg

// file: src/eppio_sync.sv
// Purpose: three stage input synchroniser with agreement filter
// Assumes: asynchronous pins
// Notes: the value moves only when stages two and three agree
`timescale 1ns/1ps
module eppio_sync #(
	parameter int WIDTH = 8
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	generate
		if (WIDTH < 1) begin : g_bad
			$error("eppio_sync needs at least one bit");
		end
	endgenerate

	logic [WIDTH-1:0] s1_ff, s2_ff, s3_ff, val_ff;
	logic [WIDTH-1:0] nxt_val;

	// filter: first stage is never looked at here
	always_comb begin
		nxt_val = val_ff;
		for (int i = 0; i < WIDTH; i++) begin
			if (s2_ff[i] == s3_ff[i]) begin
				nxt_val[i] = s3_ff[i];
			end
		end
	end

	// pull-ups on the pins make high the safe reset value
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s1_ff <= '1;
			s2_ff <= '1;
			s3_ff <= '1;
			val_ff <= '1;
		end else if (clk_en_i) begin
			s1_ff <= async_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			val_ff <= nxt_val;
		end
	end
	assign sync_o = val_ff;
endmodule : eppio_sync

// file: src/eppio_port.sv
// Purpose: eight pin general purpose port with io mapped byte registers
// Assumes: io cycle strobes from the host decoder, one cycle each
// Notes: read data is registered, valid one cycle after the read strobe
// Operation
// - select bit clear gives pin to native function, set gives it to port
// - select bits: pin0 0x00 b1; pins1-4 0x02 b0,1,5,6; pins5-7 0x30 b2,3,4
// - direction bits at 0x04, 0x06, 0x34 with select bit positions
// - direction bit clear makes output, set makes input
// - output pin drives the level bit written at 0x0C, 0x0E, 0x38
// - input pin level bit reads the live pin state
// - inversion register flips input level seen; pin0 at 0x2C bit 1
// - inversion bit one inverts, zero keeps; pins 4-7 cannot invert
// - output pins are low after hardware reset
// - default: pins 0-3 inputs, pins 4-7 outputs
// - registers reached by io reads and writes relative to base 0x1C00
`timescale 1ns/1ps
module eppio_port
	import eppio_pkg::*;
#(
	parameter int NPINS = 8,
	parameter logic [15:0] BASE = PORT_BLOCK_BASE
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	input wire logic [15:0] io_addr_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [7:0] io_wdata_i,
	output logic [7:0] io_rdata_o,
	output logic io_rvalid_o,
	input wire logic [7:0] native_out_i,
	input wire logic [7:0] native_oe_i,
	output logic [7:0] native_in_o,
	input wire logic [7:0] pin_i,
	output logic [7:0] pin_o,
	output logic [7:0] pin_oe_o
);
	generate
		// decode compares only the upper address byte, so the base must be 256-byte aligned
		if (NPINS != 8 || BASE[7:0] != 8'h00) begin : g_bad
			$error("eppio_port serves exactly eight pins at an aligned base");
		end
	endgenerate

	logic [7:0] func_ff, dir_ff, lvl_ff, inv_ff;
	logic [7:0] nxt_func, nxt_dir, nxt_lvl, nxt_inv;
	logic [7:0] rdata_ff, nxt_rdata;
	logic rvalid_ff, nxt_rvalid;
	logic [7:0] pout_ff, poe_ff, nin_ff;
	logic [7:0] nxt_pout, nxt_poe;
	logic [7:0] pin_sync, in_seen;
	logic hit;
	logic [7:0] off;

	eppio_sync #(.WIDTH(8)) u_sync (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.clk_en_i(clk_en_i),
		.async_i(pin_i),
		.sync_o(pin_sync)
	);

	// window decode against the block base
	assign hit = (io_addr_i[15:8] == BASE[15:8]);
	assign off = io_addr_i[7:0];

	// gather a register byte from the per-pin vector
	function automatic logic [7:0] pack(input logic [7:0] v, input logic [1:0] grp);
		logic [7:0] r;
		r = 8'h00;
		for (int p = 0; p < 8; p++) begin
			if (PIN_GRP[p] == grp) begin
				r[PIN_BIT[p]] = v[p];
			end
		end
		return r;
	endfunction : pack

	// scatter a written byte into the per-pin vector
	function automatic logic [7:0] unpack(input logic [7:0] v, input logic [1:0] grp,
		input logic [7:0] wd);
		logic [7:0] r;
		r = v;
		for (int p = 0; p < 8; p++) begin
			if (PIN_GRP[p] == grp) begin
				r[p] = wd[PIN_BIT[p]];
			end
		end
		return r;
	endfunction : unpack

	// input level after optional inversion; upper pins never invert
	assign in_seen = pin_sync ^ (inv_ff & INV_CAPABLE);

	// register file next state
	always_comb begin
		nxt_func = func_ff;
		nxt_dir = dir_ff;
		nxt_lvl = lvl_ff;
		nxt_inv = inv_ff;
		nxt_rvalid = io_rd_i;
		nxt_rdata = 8'h00;
		if (io_wr_i && hit) begin
			unique case (off)
				OFF_FUNC_A: nxt_func = unpack(func_ff, 2'h0, io_wdata_i);
				OFF_FUNC_B: nxt_func = unpack(func_ff, 2'h1, io_wdata_i);
				OFF_FUNC_C: nxt_func = unpack(func_ff, 2'h2, io_wdata_i);
				OFF_DIR_A: nxt_dir = unpack(dir_ff, 2'h0, io_wdata_i);
				OFF_DIR_B: nxt_dir = unpack(dir_ff, 2'h1, io_wdata_i);
				OFF_DIR_C: nxt_dir = unpack(dir_ff, 2'h2, io_wdata_i);
				OFF_LVL_A: nxt_lvl = unpack(lvl_ff, 2'h0, io_wdata_i);
				OFF_LVL_B: nxt_lvl = unpack(lvl_ff, 2'h1, io_wdata_i);
				OFF_LVL_C: nxt_lvl = unpack(lvl_ff, 2'h2, io_wdata_i);
				OFF_INV_A: nxt_inv = unpack(inv_ff, 2'h0, io_wdata_i) & INV_CAPABLE;
				OFF_INV_B: nxt_inv = unpack(inv_ff, 2'h1, io_wdata_i) & INV_CAPABLE;
				default: ;
			endcase
		end
		if (io_rd_i && hit) begin
			unique case (off)
				OFF_FUNC_A: nxt_rdata = pack(func_ff, 2'h0);
				OFF_FUNC_B: nxt_rdata = pack(func_ff, 2'h1);
				OFF_FUNC_C: nxt_rdata = pack(func_ff, 2'h2);
				OFF_DIR_A: nxt_rdata = pack(dir_ff, 2'h0);
				OFF_DIR_B: nxt_rdata = pack(dir_ff, 2'h1);
				OFF_DIR_C: nxt_rdata = pack(dir_ff, 2'h2);
				// inputs read live pin, outputs read stored level
				OFF_LVL_A: nxt_rdata = pack((dir_ff & in_seen) | (~dir_ff & lvl_ff), 2'h0);
				OFF_LVL_B: nxt_rdata = pack((dir_ff & in_seen) | (~dir_ff & lvl_ff), 2'h1);
				OFF_LVL_C: nxt_rdata = pack((dir_ff & in_seen) | (~dir_ff & lvl_ff), 2'h2);
				OFF_INV_A: nxt_rdata = pack(inv_ff, 2'h0);
				OFF_INV_B: nxt_rdata = pack(inv_ff, 2'h1);
				default: nxt_rdata = 8'h00; // unmapped offsets read zero
			endcase
		end
	end

	// pin drive: port owns the pin only when selected, direction 0 drives
	always_comb begin
		for (int p = 0; p < 8; p++) begin
			if (func_ff[p]) begin
				nxt_poe[p] = ~dir_ff[p];
				nxt_pout[p] = lvl_ff[p];
			end else begin
				nxt_poe[p] = native_oe_i[p];
				nxt_pout[p] = native_out_i[p];
			end
		end
	end

	// registers; reset sets the board default and low outputs
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			func_ff <= RST_FUNC;
			dir_ff <= RST_DIR;
			lvl_ff <= RST_LVL;
			inv_ff <= RST_INV;
			rdata_ff <= 8'h00;
			rvalid_ff <= 1'b0;
			pout_ff <= RST_LVL;
			poe_ff <= ~RST_DIR;
			nin_ff <= 8'hFF;
		end else if (clk_en_i) begin
			func_ff <= nxt_func;
			dir_ff <= nxt_dir;
			lvl_ff <= nxt_lvl;
			inv_ff <= nxt_inv;
			rdata_ff <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
			pout_ff <= nxt_pout;
			poe_ff <= nxt_poe;
			nin_ff <= pin_sync;
		end
	end

	assign io_rdata_o = rdata_ff;
	assign io_rvalid_o = rvalid_ff;
	assign pin_o = pout_ff;
	assign pin_oe_o = poe_ff;
	assign native_in_o = nin_ff;

	// spot checks: one pin per register group is enough to catch a shifted bit table
	AST_NATIVE_PASS: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		clk_en_i && !func_ff[5] ##1 clk_en_i |-> pin_oe_o[5] == $past(native_oe_i[5]))
		else $error("native pin5 enable not passed");
	AST_NATIVE_OUT: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		clk_en_i && !func_ff[5] |=> pin_o[5] == $past(native_out_i[5]))
		else $error("native pin5 level not passed");
	AST_SEL_MAP: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		clk_en_i && io_wr_i && io_addr_i == {BASE[15:8], OFF_FUNC_C}
		|=> func_ff[5] == $past(io_wdata_i[2]))
		else $error("pin5 select bit misplaced");
	AST_DIR_MAP: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		clk_en_i && io_wr_i && io_addr_i == {BASE[15:8], OFF_DIR_B}
		|=> dir_ff[4] == $past(io_wdata_i[6]))
		else $error("pin4 direction bit misplaced");
	AST_LVL_MAP: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		clk_en_i && io_wr_i && io_addr_i == {BASE[15:8], OFF_LVL_C}
		|=> lvl_ff[7] == $past(io_wdata_i[4]))
		else $error("pin7 level bit misplaced");
	AST_INV_MAP: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		clk_en_i && io_wr_i && io_addr_i == {BASE[15:8], OFF_INV_A}
		|=> inv_ff[0] == $past(io_wdata_i[1]))
		else $error("pin0 inversion bit misplaced");
	AST_DRIVE: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		clk_en_i && func_ff[7] && !dir_ff[7] ##1 clk_en_i |-> pin_oe_o[7] && pin_o[7] == $past(lvl_ff[7]))
		else $error("output pin7 not driven from level");
	AST_INPUT_HIZ: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		clk_en_i && func_ff[2] && dir_ff[2] ##1 clk_en_i |-> !pin_oe_o[2])
		else $error("input pin2 driven");
	AST_LIVE_READ: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		clk_en_i && io_rd_i && io_addr_i == {BASE[15:8], OFF_LVL_A} && dir_ff[0]
		|=> io_rdata_o[1] == $past(pin_sync[0] ^ inv_ff[0]))
		else $error("pin0 level read not live");
	AST_NO_INV_HI: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		inv_ff[7:4] == 4'h0)
		else $error("upper pin inversion set");
	AST_RVALID: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		clk_en_i && io_rd_i && io_addr_i[15:8] != BASE[15:8] |=> io_rvalid_o && io_rdata_o == 8'h00)
		else $error("outside read not zero");
	AST_RVALID_ANY: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		clk_en_i && io_rd_i |=> io_rvalid_o)
		else $error("read strobe got no reply");
endmodule : eppio_port

// file: sim/eppio_board.sv
// Purpose: board side model of the eight port pins
// Assumes: pins 0-3 are pulled high on the module
// Notes: port drive wins, then board drive, else the pull-up level on pins 0-3
`timescale 1ns/1ps
module eppio_board (
	input wire logic [7:0] pin_o_i,
	input wire logic [7:0] pin_oe_i,
	input wire logic [7:0] drv_oe_i,
	input wire logic [7:0] drv_val_i,
	output logic [7:0] pin_level_o
);
	// released: pins 0-3 go to their pull-up, unpulled pins show the inverse of the current pin_o level
	always_comb begin
		for (int p = 0; p < 8; p++) begin
			if (pin_oe_i[p]) pin_level_o[p] = pin_o_i[p];
			else if (drv_oe_i[p]) pin_level_o[p] = drv_val_i[p];
			else pin_level_o[p] = (p < 4) ? 1'b1 : ~pin_o_i[p];
		end
	end
endmodule : eppio_board

// file: sim/tb_top.sv
// Purpose: self-checking bench for the eight pin io port
// Assumes: io strobes driven on the falling edge, one cycle each
// Notes: table rows cover reset values, readback masks and refusals
`timescale 1ns/1ps
module tb_top import eppio_pkg::*;;
	`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
		$display("Error at %0t: got %h expected %h", $time, g, e); end end
	typedef struct packed {logic wr; logic [7:0] off; logic [7:0] d; logic [7:0] exp;} eppio_row_t;
	int n_errors = 0;
	int n_compared = 0;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic clk_en = 1'b1;
	logic io_wr = 1'b0;
	logic io_rd = 1'b0;
	logic rvalid;
	logic [7:0] hi = PORT_BLOCK_BASE[15:8];
	logic [7:0] off = 8'h00, wd = 8'h00, nout = 8'h00, noe = 8'h00, dv = 8'hFF, doe = 8'h00;
	logic [7:0] rd, rdata, pin_o, pin_oe, pin_i, nin;
	wire [15:0] io_addr = {hi, off};
	// reset reads first, then writes whose readback shows the masks
	eppio_row_t rows [20] = '{
		'{1'b0, OFF_FUNC_A, 8'h00, 8'h02}, '{1'b0, OFF_FUNC_B, 8'h00, 8'h63},
		'{1'b0, OFF_FUNC_C, 8'h00, 8'h1C}, '{1'b0, OFF_DIR_A, 8'h00, 8'h02},
		'{1'b0, OFF_DIR_B, 8'h00, 8'h23}, '{1'b0, OFF_DIR_C, 8'h00, 8'h00},
		'{1'b0, OFF_INV_A, 8'h00, 8'h00}, '{1'b0, OFF_LVL_A, 8'h00, 8'h02},
		'{1'b0, OFF_LVL_B, 8'h00, 8'h23}, '{1'b0, OFF_LVL_C, 8'h00, 8'h00},
		'{1'b1, OFF_INV_A, 8'hFF, 8'h02}, '{1'b0, OFF_LVL_A, 8'h00, 8'h00},
		'{1'b1, OFF_INV_B, 8'hFF, 8'h23}, '{1'b0, OFF_LVL_B, 8'h00, 8'h00},
		'{1'b1, OFF_INV_B, 8'h00, 8'h00}, '{1'b1, OFF_INV_A, 8'h00, 8'h00},
		'{1'b1, 8'h10, 8'hFF, 8'h00}, '{1'b1, OFF_LVL_C, 8'hFF, 8'h1C},
		'{1'b1, OFF_DIR_B, 8'hFF, 8'h63}, '{1'b1, OFF_DIR_B, 8'h23, 8'h23}};
	eppio_port u_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en),
		.io_addr_i(io_addr), .io_wr_i(io_wr), .io_rd_i(io_rd), .io_wdata_i(wd),
		.io_rdata_o(rdata), .io_rvalid_o(rvalid), .native_out_i(nout), .native_oe_i(noe),
		.native_in_o(nin), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe));
	eppio_board u_board (.pin_o_i(pin_o), .pin_oe_i(pin_oe), .drv_oe_i(doe),
		.drv_val_i(dv), .pin_level_o(pin_i));
	// free running clock, 10 ns period
	initial begin
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	task automatic settle(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask : settle
	task automatic summarize();
		$display("compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : summarize
	// strobe stands one cycle, taken at the rising edge in between
	task automatic io_write(input logic [7:0] o, input logic [7:0] d);
		@(negedge ref_clk_i);
		off = o;
		wd = d;
		io_wr = 1'b1;
		@(negedge ref_clk_i);
		io_wr = 1'b0;
	endtask : io_write
	// bounded wait for the one-cycle read answer
	task automatic io_read(input logic [7:0] o, output logic [7:0] d);
		@(negedge ref_clk_i);
		off = o;
		io_rd = 1'b1;
		@(negedge ref_clk_i);
		io_rd = 1'b0;
		for (int i = 0; i < 4 && rvalid !== 1'b1; i++) @(negedge ref_clk_i);
		`CHK(rvalid, 1'b1)
		if (rvalid !== 1'b1) summarize();
		else d = rdata;
	endtask : io_read
	initial begin
		settle(2);
		sys_rst_i = 1'b0;
		foreach (rows[i]) begin
			if (rows[i].wr) io_write(rows[i].off, rows[i].d);
			io_read(rows[i].off, rd);
			`CHK(rd, rows[i].exp)
		end
		$display("table test done");
		// pin 4 high, pin 0 turned to an output driving high
		io_write(OFF_LVL_B, 8'h40);
		io_write(OFF_DIR_A, 8'h00);
		io_write(OFF_LVL_A, 8'h02);
		settle(2);
		`CHK(pin_oe, 8'hF1)
		`CHK(pin_o & pin_oe, 8'hF1)
		$display("output test done");
		// board pulls pin 1 low; synchroniser needs a few cycles
		doe = 8'h02;
		dv = 8'h00;
		settle(8);
		io_read(OFF_LVL_B, rd);
		`CHK(rd, 8'h62)
		`CHK(nin, 8'hFD)
		io_write(OFF_INV_B, 8'h01);
		io_read(OFF_LVL_B, rd);
		`CHK(rd, 8'h63)
		$display("input test done");
		// native pins must ignore port direction and level writes
		noe = 8'hA0;
		nout = 8'h20;
		io_write(OFF_FUNC_C, 8'h00);
		io_write(OFF_LVL_C, 8'h00);
		io_write(OFF_DIR_C, 8'h1C);
		settle(2);
		`CHK(pin_oe, 8'hB1)
		`CHK(pin_o & pin_oe, 8'h31)
		io_write(OFF_FUNC_C, 8'h1C);
		settle(2);
		`CHK(pin_oe, 8'h11)
		$display("native test done");
		// outside the window nothing answers with data, but the strobe still gets a reply
		hi = 8'h00;
		io_read(OFF_FUNC_A, rd);
		`CHK(rd, 8'h00)
		hi = PORT_BLOCK_BASE[15:8];
		// a write while the clock enable is low must not land
		clk_en = 1'b0;
		io_write(OFF_FUNC_A, 8'h00);
		settle(1);
		`CHK(pin_oe, 8'h11)
		clk_en = 1'b1;
		io_read(OFF_FUNC_A, rd);
		`CHK(rd, 8'h02)
		$display("window and freeze test done");
		// second reset in mid-run
		sys_rst_i = 1'b1;
		settle(1);
		`CHK(pin_o, 8'h00)
		`CHK(pin_oe, 8'hF0)
		sys_rst_i = 1'b0;
		settle(2);
		`CHK(pin_o, 8'h00)
		`CHK(pin_oe, 8'hF0)
		io_read(OFF_DIR_C, rd);
		`CHK(rd, 8'h00)
		io_read(OFF_INV_B, rd);
		`CHK(rd, 8'h00)
		$display("reset test done");
		summarize();
	end
endmodule : tb_top
